// *** logic/bstp_pkg.sv ***
// Constants and types of the boundary-scan test port
package bstp_pkg;
  localparam int BSR_LEN = 109;
  localparam int Q_W     = 36;
  localparam int PIN_W   = 72;
  localparam int Q_LSB   = 0;
  localparam int PIN_LSB = 36;
  localparam int OE_CELL = 108;
  localparam int IR_W    = 3;
  localparam int ID_W    = 32;
  localparam int REV_W   = 3;
  localparam int DEV_W   = 17;
  localparam int VEND_W  = 11;

  localparam logic [2:0] IR_EXTEST  = 3'h0;
  localparam logic [2:0] IR_IDCODE  = 3'h1;
  localparam logic [2:0] IR_SAMPLEZ = 3'h2;
  localparam logic [2:0] IR_SAMPLE  = 3'h4;
  localparam logic [2:0] IR_BYPASS  = 3'h7;
  localparam logic [1:0] IR_CAP_PAT = 2'h1;
  localparam logic       IR_CAP_MSB = 1'h0;
  localparam logic       ID_PRESENT = 1'h1;
  localparam logic       BYP_CAP    = 1'h0;
  localparam logic       OE_PRESET  = 1'h0;

  typedef enum logic [15:0] {
    ST_RESET  = 16'h0001,
    ST_IDLE   = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SH_DR  = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PAU_DR = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SH_IR  = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PAU_IR = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } bstp_state_t;

  typedef enum logic [2:0] {
    SEL_BYP = 3'h1,
    SEL_ID  = 3'h2,
    SEL_BSR = 3'h4
  } bstp_sel_t;

  typedef struct packed {
    logic extest;
    logic float_q;
  } bstp_mode_t;

  typedef struct packed {
    logic             oe;
    logic [PIN_W-1:0] pins;
    logic [Q_W-1:0]   q;
  } bstp_cells_t;
endpackage

// *** logic/bstp_top.sv ***
// Boundary-scan test port of the memory, with output pin mux
`timescale 1ns/1ps

// What this block does
// - Test clock held low keeps port idle
// - Inputs sampled rising, outputs updated falling edge
// - Serial out driven only in shift states
// - Serial in at MSB, out from LSB
// - Five high mode-select edges reset controller
// - Power-up reset floats serial output
// - Three-bit instruction, identification after reset
// - Instruction capture loads 01 in lows
// - New instruction active at instruction update
// - One-bit bypass captures zero
// - Boundary captures pins, shifts in data-shift
// - Identification word captured then shifted out
// - Float instruction floats data outputs
// - Sample snapshot leaves memory undisturbed
// - Captured data out while preload in
// - Data update copies cells to latches
// - External test drives latches onto pins
// - Cell 108 enables outputs under external test
// - Cell 108 latch preset low on reset
// - Instruction code decode table
// - Identification word field layout
module bstp_top #(
  parameter logic [2:0]  ID_REV  = 3'h0,  // Arbitrary value
  parameter logic [16:0] ID_DEV  = 17'h00a5c, // Arbitrary value
  parameter logic [10:0] ID_VEND = 11'h05a  // Arbitrary value
) (
  input  wire logic                     clk_in,
  input  wire logic                     rst_b_in,
  input  wire logic                     tck_in,
  input  wire logic                     tms_in,
  input  wire logic                     tdi_in,
  input  wire logic [bstp_pkg::Q_W-1:0]   func_q_in,
  input  wire logic                     func_q_drive_in,
  input  wire logic [bstp_pkg::PIN_W-1:0] mem_pins_in,
  output logic                          tdo_out,
  output logic                          tdo_oe_b_out,
  output logic [bstp_pkg::Q_W-1:0]        q_out,
  output logic                          q_oe_b_out
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic bstp_pkg::bstp_state_t tap_next(
    input bstp_pkg::bstp_state_t s,
    input logic                  tms
  );
    case (s)
      bstp_pkg::ST_RESET:
        tap_next = tms ? bstp_pkg::ST_RESET : bstp_pkg::ST_IDLE;
      bstp_pkg::ST_IDLE:
        tap_next = tms ? bstp_pkg::ST_SEL_DR : bstp_pkg::ST_IDLE;
      bstp_pkg::ST_SEL_DR:
        tap_next = tms ? bstp_pkg::ST_SEL_IR : bstp_pkg::ST_CAP_DR;
      bstp_pkg::ST_CAP_DR:
        tap_next = tms ? bstp_pkg::ST_EX1_DR : bstp_pkg::ST_SH_DR;
      bstp_pkg::ST_SH_DR:
        tap_next = tms ? bstp_pkg::ST_EX1_DR : bstp_pkg::ST_SH_DR;
      bstp_pkg::ST_EX1_DR:
        tap_next = tms ? bstp_pkg::ST_UPD_DR : bstp_pkg::ST_PAU_DR;
      bstp_pkg::ST_PAU_DR:
        tap_next = tms ? bstp_pkg::ST_EX2_DR : bstp_pkg::ST_PAU_DR;
      bstp_pkg::ST_EX2_DR:
        tap_next = tms ? bstp_pkg::ST_UPD_DR : bstp_pkg::ST_SH_DR;
      bstp_pkg::ST_UPD_DR:
        tap_next = tms ? bstp_pkg::ST_SEL_DR : bstp_pkg::ST_IDLE;
      bstp_pkg::ST_SEL_IR:
        tap_next = tms ? bstp_pkg::ST_RESET : bstp_pkg::ST_CAP_IR;
      bstp_pkg::ST_CAP_IR:
        tap_next = tms ? bstp_pkg::ST_EX1_IR : bstp_pkg::ST_SH_IR;
      bstp_pkg::ST_SH_IR:
        tap_next = tms ? bstp_pkg::ST_EX1_IR : bstp_pkg::ST_SH_IR;
      bstp_pkg::ST_EX1_IR:
        tap_next = tms ? bstp_pkg::ST_UPD_IR : bstp_pkg::ST_PAU_IR;
      bstp_pkg::ST_PAU_IR:
        tap_next = tms ? bstp_pkg::ST_EX2_IR : bstp_pkg::ST_PAU_IR;
      bstp_pkg::ST_EX2_IR:
        tap_next = tms ? bstp_pkg::ST_UPD_IR : bstp_pkg::ST_SH_IR;
      bstp_pkg::ST_UPD_IR:
        tap_next = tms ? bstp_pkg::ST_SEL_DR : bstp_pkg::ST_IDLE;
      default:
        tap_next = bstp_pkg::ST_RESET;
    endcase
  endfunction

  // Reserved codes fall back to bypass
  function automatic bstp_pkg::bstp_sel_t dr_sel(
    input logic [bstp_pkg::IR_W-1:0] code
  );
    case (code)
      bstp_pkg::IR_IDCODE:  dr_sel = bstp_pkg::SEL_ID;
      bstp_pkg::IR_EXTEST:  dr_sel = bstp_pkg::SEL_BSR;
      bstp_pkg::IR_SAMPLEZ: dr_sel = bstp_pkg::SEL_BSR;
      bstp_pkg::IR_SAMPLE:  dr_sel = bstp_pkg::SEL_BSR;
      bstp_pkg::IR_BYPASS:  dr_sel = bstp_pkg::SEL_BYP;
      default:              dr_sel = bstp_pkg::SEL_BYP;
    endcase
  endfunction

  // Pin mode that an instruction asks for
  function automatic bstp_pkg::bstp_mode_t mode_of(
    input logic [bstp_pkg::IR_W-1:0] code
  );
    mode_of         = '0;
    mode_of.extest  = code == bstp_pkg::IR_EXTEST;
    mode_of.float_q = code == bstp_pkg::IR_SAMPLEZ;
  endfunction

  // ------------------------------------------------------------
  // Test clock domain signals
  // ------------------------------------------------------------
  localparam logic [bstp_pkg::ID_W-1:0] ID_CODE =
    {ID_REV, ID_DEV, ID_VEND, bstp_pkg::ID_PRESENT};

  logic                          tap_rst_meta;
  logic                          tap_rst_sync;
  bstp_pkg::bstp_state_t         state;
  logic [bstp_pkg::IR_W-1:0]     ir_shift;
  logic [bstp_pkg::IR_W-1:0]     ir;
  logic                          bypass;
  logic [bstp_pkg::ID_W-1:0]     id_shift;
  logic [bstp_pkg::BSR_LEN-1:0]  bsr;
  logic [bstp_pkg::BSR_LEN-1:0]  preload;
  logic                          upd_tgl;
  bstp_pkg::bstp_mode_t          tck_mode;
  bstp_pkg::bstp_cells_t         cell_meta;
  bstp_pkg::bstp_cells_t         cell_sync;
  bstp_pkg::bstp_sel_t           sel;

  // ------------------------------------------------------------
  // Data register selection
  // ------------------------------------------------------------
  // Follows the active instruction, not the one being shifted
  assign sel = dr_sel(ir);

  // ------------------------------------------------------------
  // Power-up reset into test clock domain
  // ------------------------------------------------------------
  // No tck edge, nothing moves: the port idles with tck low
  always_ff @(posedge tck_in) begin
    tap_rst_meta <= rst_b_in;
    tap_rst_sync <= tap_rst_meta;
  end

  // ------------------------------------------------------------
  // Controller state, rising edge
  // ------------------------------------------------------------
  // Five tms-high edges reach reset from any state
  always_ff @(posedge tck_in) begin
    if (!tap_rst_sync) begin
      state <= bstp_pkg::ST_RESET;
    end else begin
      state <= tap_next(state, tms_in);
    end
  end

  // ------------------------------------------------------------
  // Pin snapshot synchronisers
  // ------------------------------------------------------------
  // Values caught here are only trustworthy if pins stand still
  always_ff @(posedge tck_in) begin
    cell_meta <= {~q_oe_b_out, mem_pins_in, q_out};
    cell_sync <= cell_meta;
  end

  // ------------------------------------------------------------
  // Instruction shift path
  // ------------------------------------------------------------
  always_ff @(posedge tck_in) begin
    if (!tap_rst_sync) begin
      ir_shift <= bstp_pkg::IR_IDCODE;
    end else if (state == bstp_pkg::ST_CAP_IR) begin
      ir_shift <= {bstp_pkg::IR_CAP_MSB, bstp_pkg::IR_CAP_PAT};
    end else if (state == bstp_pkg::ST_SH_IR) begin
      ir_shift <= {tdi_in, ir_shift[bstp_pkg::IR_W-1:1]};
    end
  end

  // ------------------------------------------------------------
  // Bypass path
  // ------------------------------------------------------------
  always_ff @(posedge tck_in) begin
    if (!tap_rst_sync) begin
      bypass <= bstp_pkg::BYP_CAP;
    end else if (state == bstp_pkg::ST_CAP_DR) begin
      bypass <= bstp_pkg::BYP_CAP;
    end else if (state == bstp_pkg::ST_SH_DR) begin
      bypass <= tdi_in;
    end
  end

  // ------------------------------------------------------------
  // Identification path
  // ------------------------------------------------------------
  always_ff @(posedge tck_in) begin
    if (!tap_rst_sync) begin
      id_shift <= ID_CODE;
    end else if (sel == bstp_pkg::SEL_ID) begin
      if (state == bstp_pkg::ST_CAP_DR) begin
        id_shift <= ID_CODE;
      end else if (state == bstp_pkg::ST_SH_DR) begin
        id_shift <= {tdi_in, id_shift[bstp_pkg::ID_W-1:1]};
      end
    end
  end

  // ------------------------------------------------------------
  // Boundary path
  // ------------------------------------------------------------
  // Capture only reads pins, so memory traffic carries on
  always_ff @(posedge tck_in) begin
    if (!tap_rst_sync) begin
      bsr <= '0;
    end else if (sel == bstp_pkg::SEL_BSR) begin
      if (state == bstp_pkg::ST_CAP_DR) begin
        bsr <= cell_sync;
      end else if (state == bstp_pkg::ST_SH_DR) begin
        bsr <= {tdi_in, bsr[bstp_pkg::BSR_LEN-1:1]};
      end
    end
  end

  // ------------------------------------------------------------
  // Instruction update, falling edge
  // ------------------------------------------------------------
  // Reserved codes are not blocked; they act as bypass
  always_ff @(negedge tck_in) begin
    if (!tap_rst_sync || state == bstp_pkg::ST_RESET) begin
      ir <= bstp_pkg::IR_IDCODE;
    end else if (state == bstp_pkg::ST_UPD_IR) begin
      ir <= ir_shift;
    end
  end

  always_ff @(negedge tck_in) begin
    if (!tap_rst_sync || state == bstp_pkg::ST_RESET) begin
      tck_mode <= '0;
    end else if (state == bstp_pkg::ST_UPD_IR) begin
      tck_mode <= mode_of(ir_shift);
    end
  end

  // ------------------------------------------------------------
  // Preload latches, falling edge
  // ------------------------------------------------------------
  always_ff @(negedge tck_in) begin
    if (!tap_rst_sync) begin
      preload <= '0;
    end else if (state == bstp_pkg::ST_RESET) begin
      preload[bstp_pkg::OE_CELL] <= bstp_pkg::OE_PRESET;
    end else if (state == bstp_pkg::ST_UPD_DR &&
                 sel == bstp_pkg::SEL_BSR) begin
      preload <= bsr;
    end
  end

  // ------------------------------------------------------------
  // Update handshake toward the memory clock
  // ------------------------------------------------------------
  // Toggles with every latch write; the memory side copies the
  // latches a few clocks later, once they have settled
  always_ff @(negedge tck_in) begin
    if (!tap_rst_sync) begin
      upd_tgl <= 1'b0;
    end else if (state == bstp_pkg::ST_RESET ||
                 (state == bstp_pkg::ST_UPD_DR &&
                  sel == bstp_pkg::SEL_BSR)) begin
      upd_tgl <= ~upd_tgl;
    end
  end

  // ------------------------------------------------------------
  // Serial output, falling edge
  // ------------------------------------------------------------
  always_ff @(negedge tck_in) begin
    if (!tap_rst_sync) begin
      tdo_oe_b_out <= 1'b1;
    end else if (state == bstp_pkg::ST_SH_IR ||
                 state == bstp_pkg::ST_SH_DR) begin
      tdo_oe_b_out <= 1'b0;
    end else begin
      tdo_oe_b_out <= 1'b1;
    end
  end

  // Holds its last bit outside shifting, the enable floats it
  always_ff @(negedge tck_in) begin
    if (!tap_rst_sync) begin
      tdo_out <= 1'b0;
    end else if (state == bstp_pkg::ST_SH_IR) begin
      tdo_out <= ir_shift[0];
    end else if (state == bstp_pkg::ST_SH_DR) begin
      case (sel)
        bstp_pkg::SEL_ID:  tdo_out <= id_shift[0];
        bstp_pkg::SEL_BSR: tdo_out <= bsr[0];
        default:           tdo_out <= bypass;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Memory clock domain crossing
  // ------------------------------------------------------------
  bstp_pkg::bstp_mode_t    mode_meta;
  bstp_pkg::bstp_mode_t    mode_sync;
  logic                    tgl_meta;
  logic                    tgl_sync;
  logic                    tgl_seen;
  logic [bstp_pkg::Q_W-1:0] q_pre;
  logic                    oe_pre;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      mode_meta <= '0;
      mode_sync <= '0;
    end else begin
      mode_meta <= tck_mode;
      mode_sync <= mode_meta;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      tgl_meta <= 1'b0;
      tgl_sync <= 1'b0;
      tgl_seen <= 1'b0;
    end else begin
      tgl_meta <= upd_tgl;
      tgl_sync <= tgl_meta;
      tgl_seen <= tgl_sync;
    end
  end

  // Preload stays still between updates, so a late copy is safe
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      q_pre  <= '0;
      oe_pre <= bstp_pkg::OE_PRESET;
    end else if (tgl_sync != tgl_seen) begin
      q_pre  <= preload[bstp_pkg::Q_LSB +: bstp_pkg::Q_W];
      oe_pre <= preload[bstp_pkg::OE_CELL];
    end
  end

  // ------------------------------------------------------------
  // Memory output pins
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      q_out <= '0;
    end else if (mode_sync.extest && !mode_sync.float_q) begin
      q_out <= q_pre;
    end else begin
      q_out <= func_q_in;
    end
  end

  // Float wins if a mode switch shows one mixed cycle
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      q_oe_b_out <= 1'b1;
    end else if (mode_sync.float_q) begin
      q_oe_b_out <= 1'b1;
    end else if (mode_sync.extest) begin
      q_oe_b_out <= ~oe_pre;
    end else begin
      q_oe_b_out <= ~func_q_drive_in;
    end
  end

endmodule

// *** verification/bstp_ctl_model.sv ***
// Board test controller model driving the serial test link
`timescale 1ns/1ps
module bstp_ctl_model (
  output logic      tck_out,
  output logic      tms_out,
  output logic      tdi_out,
  input  wire logic tdo_in,
  input  wire logic tdo_oe_b_in
);
  logic seen;

  initial begin
    seen = 1'b0;
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
  end

  // One 64 ns tck cycle, clock stands low between calls
  task automatic tick(input logic t, input logic d);
    tms_out = t;
    tdi_out = d;
    #16.3 tck_out = 1'b1;
    seen = tdo_oe_b_in ? ~seen : tdo_in;
    #32 tck_out = 1'b0;
    tdi_out = 1'b1;
    #15.7;
  endtask

  task automatic reset_tap();
    repeat (5) tick(1'b1, 1'b1);
    tick(1'b0, 1'b1);
  endtask

  // From idle: capture, shift n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout);
    dout = '0;
    tick(1'b1, 1'b1);
    if (ir) tick(1'b1, 1'b1);
    tick(1'b0, 1'b1);
    tick(1'b0, 1'b1);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i]);
      dout[i] = seen;
    end
    tick(1'b1, 1'b1);
    tick(1'b0, 1'b1);
  endtask
endmodule

// *** verification/bstp_properties.sv ***
// Concurrent checks on the test port pins
`timescale 1ns/1ps
module bstp_properties (
  input wire logic                       clk_in,
  input wire logic                       rst_b_in,
  input wire logic                       tck_in,
  input wire logic                       tms_in,
  input wire logic                       tdo_out,
  input wire logic                       tdo_oe_b_out,
  input wire logic [bstp_pkg::Q_W-1:0]   q_out,
  input wire logic                       q_oe_b_out
);
  tdo_fall_edge_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $changed(tdo_out) |-> !tck_in) else $error("tdo moved on rising tck");
  oe_fall_edge_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $changed(tdo_oe_b_out) |-> !tck_in) else $error("tdo enable moved");
  shift_entry_a: assert property (@(posedge tck_in) disable iff (!rst_b_in)
    $fell(tdo_oe_b_out) |-> !$past(tms_in)) else $error("bad drive");
  shift_hold_a: assert property (@(posedge tck_in) disable iff (!rst_b_in)
    !tdo_oe_b_out && !tms_in |=> !tdo_oe_b_out) else $error("shift lost");
  shift_exit_a: assert property (@(posedge tck_in) disable iff (!rst_b_in)
    !tdo_oe_b_out && tms_in |=> tdo_oe_b_out) else $error("exit drives");
  tms_reset_a: assert property (@(posedge tck_in) disable iff (!rst_b_in)
    tms_in [*5] |=> tdo_oe_b_out) else $error("tms reset failed");
  por_float_a: assert property (@(posedge tck_in)
    !rst_b_in [*4] |=> tdo_oe_b_out) else $error("tdo not floated");
  pin_reset_a: assert property (@(posedge clk_in) !rst_b_in |=>
    q_oe_b_out && q_out == '0) else $error("pins not reset");
  cover property (@(posedge tck_in) disable iff (!rst_b_in)
    $fell(tdo_oe_b_out));
  cover property (@(posedge tck_in) disable iff (!rst_b_in) tms_in [*5]);
  cover property (@(posedge clk_in) disable iff (!rst_b_in)
    $rose(q_oe_b_out));
endmodule

bind bstp_top bstp_properties chk (.clk_in(clk_in), .rst_b_in(rst_b_in),
  .tck_in(tck_in), .tms_in(tms_in), .tdo_out(tdo_out),
  .tdo_oe_b_out(tdo_oe_b_out), .q_out(q_out), .q_oe_b_out(q_oe_b_out));

// *** verification/bstp_top_tb.sv ***
// Self-checking bench of the boundary-scan test port
`timescale 1ns/1ps
module bstp_top_tb;
  localparam logic [2:0]   REV  = 3'h5;      // Arbitrary value
  localparam logic [16:0]  DEV  = 17'h0a3c1; // Arbitrary value
  localparam logic [10:0]  VEND = 11'h2b3;   // Arbitrary value
  localparam logic [127:0] ID   = {96'h0, REV, DEV, VEND, 1'b1};
  logic                         clk, rst_b, tck, tms, tdi, tdo, drive;
  logic                         tdo_oe_b, q_oe_b;
  logic [bstp_pkg::Q_W-1:0]     fq, q;
  logic [bstp_pkg::PIN_W-1:0]   pins;
  logic [127:0]                 dout, pat;
  int                           fail_count, total_checks;

  bstp_top #(.ID_REV(REV), .ID_DEV(DEV), .ID_VEND(VEND)) dut (
    .clk_in(clk), .rst_b_in(rst_b), .tck_in(tck), .tms_in(tms),
    .tdi_in(tdi), .func_q_in(fq), .func_q_drive_in(drive),
    .mem_pins_in(pins), .tdo_out(tdo), .tdo_oe_b_out(tdo_oe_b),
    .q_out(q), .q_oe_b_out(q_oe_b));
  bstp_ctl_model ctl (.tck_out(tck), .tms_out(tms), .tdi_out(tdi),
    .tdo_in(tdo), .tdo_oe_b_in(tdo_oe_b));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [127:0] exp,
                       input logic [127:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    if (fail_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Instruction load, then time for the mode to reach the pins
  task automatic load(input logic [2:0] code);
    ctl.scan(1'b1, 3, {125'h0, code}, dout);
    check("ir capture", 128'h1, dout);
    repeat (8) @(posedge clk);
    #1;
  endtask

  initial begin
    #400000;
    fail_count++;
    print_verdict();
  end

  initial begin
    rst_b = 1'b0;
    drive = 1'b1;
    fq = 36'h123456789;
    pins = 72'ha5_0f1e_2d3c_4b5a_6978;
    fail_count = 0;
    total_checks = 0;
    repeat (12) ctl.tick(1'b1, 1'b1);
    @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (3) ctl.tick(1'b1, 1'b1);
    ctl.tick(1'b0, 1'b1);
    ctl.scan(1'b0, 32, '0, dout);
    check("id word", ID, dout);
    check("func q", fq, q);
    load(3'h7);
    ctl.scan(1'b0, 8, 128'hb5, dout);
    check("bypass", 128'h6a, dout);
    load(3'h4);
    pat = {19'h0, 1'b1, 72'hc3_5a5a_0ff0_1234_abcd, 36'h9abcdef01};
    ctl.scan(1'b0, 109, pat, dout);
    check("sample", {19'h0, 1'b1, pins, fq}, dout);
    check("sample q", fq, q);
    load(3'h2);
    check("float", 1'b1, q_oe_b);
    load(3'h0);
    check("extest q", pat[35:0], q);
    check("extest oe", 1'b0, q_oe_b);
    pat[108] = 1'b0;
    ctl.scan(1'b0, 109, pat, dout);
    check("extest cap", {19'h0, 1'b1, pins, pat[35:0]}, dout);
    repeat (8) @(posedge clk);
    #1;
    check("extest float", 1'b1, q_oe_b);
    load(3'h7);
    fq = 36'h0badc0de5;
    repeat (2) @(posedge clk);
    #1;
    check("func oe", 1'b0, q_oe_b);
    check("func q new", fq, q);
    drive = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("func float", 1'b1, q_oe_b);
    drive = 1'b1;
    load(3'h4);
    ctl.scan(1'b0, 109, {19'h0, 1'b1, 108'h0}, dout);
    ctl.reset_tap();
    ctl.scan(1'b0, 32, '0, dout);
    check("id after reset", ID, dout);
    load(3'h0);
    check("preset oe", 1'b1, q_oe_b);
    print_verdict();
  end
endmodule
